// ---- hdl/ient_seq.sv ----
// Purpose: sequences interrupt entry, interrupt return, subroutine call linkage and return
// Assumes: memory answers each request with mem_ack_in; requests are taken only when idle
// Notes: one memory access at a time; the stack is plain memory, so nesting depth is bounded only by the 16-bit stack pointer
//   the stack pointer wraps silently at zero; software keeps the stack in range
//   irq_ack_out pulses once per entry, the cycle after the interrupt is taken
//
// Operation
// - on interrupt, push status word then instruction pointer, predecrementing stack pointer
// - after saving, fetch new pointer and status from two adjacent vector words
// - lower vector word loads pointer, following word loads status word
// - loaded status word sets operating mode and register set for the handler
// - vector words are ordinary writable memory, so software controls them
// - interrupt return pops pointer then status, incrementing stack pointer after each
// - subroutine return through the instruction pointer pops top word into it
// - entries and calls nest freely on one last-in-first-out stack
module ient_seq
  import ient_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // requests from the instruction sequencer
  input wire logic irq_req_in,
  input wire logic [IENT_VEC_W-1:0] irq_vector_in,
  input wire logic instr_boundary_in,
  input wire logic return_from_interrupt_op_in,
  input wire logic subroutine_call_op_in,
  input wire logic [15:0] call_target_in,
  input wire logic subroutine_return_op_in,
  // memory port
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  // architectural state
  output logic [15:0] next_instruction_pointer_out,
  output logic [15:0] processor_status_word_out,
  output logic [15:0] stack_pointer_register_out,
  output logic [1:0] cur_mode_out,
  output logic reg_set_out,
  output logic busy_out,
  output logic irq_ack_out
);
  ient_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] psw_q, psw_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] vec_q, vec_d;
  logic req_q, req_d;
  logic we_q, we_d;
  logic [15:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic ack_q, ack_d;

  // next-state logic; each memory step waits for its acknowledge
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    psw_d = psw_q;
    sp_d = sp_q;
    vec_d = vec_q;
    req_d = req_q;
    we_d = we_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    ack_d = 1'b0;
    unique case (state_q)
      // idle: requests are looked at only here, so nothing is queued while busy
      IENT_IDLE: begin
        // interrupt outranks the instruction ops; all only at a boundary
        if (instr_boundary_in && irq_req_in) begin
          // pushes and fetches run as one block; nothing new is taken until idle
          vec_d = {{(16 - IENT_VEC_W){1'b0}}, irq_vector_in};
          sp_d = sp_q - IENT_WORD_STEP;
          addr_d = sp_q - IENT_WORD_STEP;
          wdata_d = psw_q;
          we_d = 1'b1;
          req_d = 1'b1;
          ack_d = 1'b1;
          state_d = IENT_PUSH_PSW;
        end else if (instr_boundary_in && return_from_interrupt_op_in) begin
          // interrupt return: top word is the pointer, status lies above it
          addr_d = sp_q;
          we_d = 1'b0;
          req_d = 1'b1;
          state_d = IENT_POP_PC;
        end else if (instr_boundary_in && subroutine_call_op_in) begin
          // call: pointer is the linkage, target waits in vec_q until the push lands
          sp_d = sp_q - IENT_WORD_STEP;
          addr_d = sp_q - IENT_WORD_STEP;
          wdata_d = pc_q;
          vec_d = call_target_in;
          we_d = 1'b1;
          req_d = 1'b1;
          state_d = IENT_CALL_PUSH;
        end else if (instr_boundary_in && subroutine_return_op_in) begin
          // return through the pointer: one read, one step up
          addr_d = sp_q;
          we_d = 1'b0;
          req_d = 1'b1;
          state_d = IENT_RET_PC;
        end
      end
      // status word is written; next the pointer goes one word lower
      IENT_PUSH_PSW: begin
        if (mem_ack_in) begin
          sp_d = sp_q - IENT_WORD_STEP;
          addr_d = sp_q - IENT_WORD_STEP;
          wdata_d = pc_q;
          state_d = IENT_PUSH_PC;
        end
      end
      // pointer is written; the vector is read only after both pushes
      IENT_PUSH_PC: begin
        if (mem_ack_in) begin
          addr_d = vec_q;
          we_d = 1'b0;
          state_d = IENT_FETCH_PC;
        end
      end
      // lower vector word becomes the handler address
      IENT_FETCH_PC: begin
        if (mem_ack_in) begin
          pc_d = mem_rdata_in;
          addr_d = vec_q + IENT_WORD_STEP;
          state_d = IENT_FETCH_PSW;
        end
      end
      // following word becomes the status, mode and register set with it
      IENT_FETCH_PSW: begin
        if (mem_ack_in) begin
          psw_d = mem_rdata_in;
          req_d = 1'b0;
          state_d = IENT_IDLE;
        end
      end
      // first pop restores the pointer of the interrupted code
      IENT_POP_PC: begin
        if (mem_ack_in) begin
          pc_d = mem_rdata_in;
          sp_d = sp_q + IENT_WORD_STEP;
          addr_d = sp_q + IENT_WORD_STEP;
          state_d = IENT_POP_PSW;
        end
      end
      // second pop restores its status; stack pointer ends four bytes up
      IENT_POP_PSW: begin
        if (mem_ack_in) begin
          psw_d = mem_rdata_in;
          sp_d = sp_q + IENT_WORD_STEP;
          req_d = 1'b0;
          state_d = IENT_IDLE;
        end
      end
      // single pop for a subroutine return
      IENT_RET_PC: begin
        if (mem_ack_in) begin
          pc_d = mem_rdata_in;
          sp_d = sp_q + IENT_WORD_STEP;
          req_d = 1'b0;
          state_d = IENT_IDLE;
        end
      end
      // jump only once the linkage word is safely on the stack
      IENT_CALL_PUSH: begin
        if (mem_ack_in) begin
          pc_d = vec_q;
          req_d = 1'b0;
          state_d = IENT_IDLE;
        end
      end
      // unused codes drop any access and fall back to idle
      default: begin
        req_d = 1'b0;
        state_d = IENT_IDLE;
      end
    endcase
  end

  // registers; reset leaves the sequencer idle with no memory request
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= IENT_IDLE;
      pc_q <= IENT_PC_RESET;
      psw_q <= IENT_PSW_RESET;
      sp_q <= IENT_SP_RESET;
      vec_q <= 16'h0000;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      psw_q <= psw_d;
      sp_q <= sp_d;
      vec_q <= vec_d;
      req_q <= req_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      ack_q <= ack_d;
    end
  end

  // outputs straight from flip-flops
  assign mem_req_out = req_q;
  assign mem_we_out = we_q;
  assign mem_addr_out = addr_q;
  assign mem_wdata_out = wdata_q;
  assign next_instruction_pointer_out = pc_q;
  assign processor_status_word_out = psw_q;
  assign stack_pointer_register_out = sp_q;
  assign cur_mode_out = psw_q[IENT_MODE_HI:IENT_MODE_LO];
  assign reg_set_out = psw_q[IENT_RSET_BIT];
  assign busy_out = req_q;
  assign irq_ack_out = ack_q;
endmodule : ient_seq

// ---- hdl/ient_pkg.sv ----
// Purpose: shared constants for the interrupt entry and return sequencer
// Assumes: 16-bit words, byte addressing, word stack in steps of two
// Notes: status field positions are a plain layout for this block
package ient_pkg;
  localparam int IENT_DW = 16;
  localparam logic [15:0] IENT_WORD_STEP = 16'h0002;
  localparam logic [15:0] IENT_SP_RESET = 16'h0000;
  localparam logic [15:0] IENT_PC_RESET = 16'h0000;
  localparam logic [15:0] IENT_PSW_RESET = 16'h0000;
  localparam int IENT_MODE_HI = 15;
  localparam int IENT_MODE_LO = 14;
  localparam int IENT_RSET_BIT = 11;
  localparam int IENT_VEC_W = 9;
  typedef enum logic [3:0] {
    IENT_IDLE = 4'h0,
    IENT_PUSH_PSW = 4'h1,
    IENT_PUSH_PC = 4'h2,
    IENT_FETCH_PC = 4'h3,
    IENT_FETCH_PSW = 4'h4,
    IENT_POP_PC = 4'h5,
    IENT_POP_PSW = 4'h6,
    IENT_RET_PC = 4'h7,
    IENT_CALL_PUSH = 4'h8
  } ient_state_t;
endpackage : ient_pkg

// ---- tb/ient_mem_model.sv ----
// Purpose: memory and vector words behind the sequencer
// Assumes: one access per request, ack after ack_delay_in cycles
// Notes: idle read data is inverted, so stale data never matches
module ient_mem_model (
  input wire logic clk_sys_in,
  input wire logic mem_req_out,
  input wire logic mem_we_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic [15:0] mem_wdata_out,
  input wire logic [3:0] ack_delay_in,
  output logic mem_ack_in,
  output logic [15:0] mem_rdata_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] m [0:32767]; // vectors are plain writable words
  logic [3:0] cnt_q;
  // count out the delay, then one ack pulse and the write lands
  // plain always: the bench also loads vector words into m directly
  always @(posedge clk_sys_in) begin
    mem_ack_in <= 1'h0;
    cnt_q <= cnt_q + 4'h1;
    if (!mem_req_out || mem_ack_in) cnt_q <= 4'h0;
    else if (cnt_q == ack_delay_in) begin
      mem_ack_in <= 1'h1;
      if (mem_we_out) m[mem_addr_out[15:1]] <= mem_wdata_out;
    end
  end
  assign mem_rdata_in = mem_ack_in ? m[mem_addr_out[15:1]] : ~m[mem_addr_out[15:1]];
endmodule : ient_mem_model

// ---- tb/ient_properties.sv ----
// Purpose: port checks for the sequencer
// Assumes: one clock, sync reset
// Notes: bound to every sequencer
module ient_chk
  import ient_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic instr_boundary_in,
  input wire logic mem_ack_in,
  input wire logic mem_req_out,
  input wire logic mem_we_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic [15:0] mem_wdata_out,
  input wire logic [15:0] processor_status_word_out,
  input wire logic [15:0] stack_pointer_register_out,
  input wire logic [1:0] cur_mode_out,
  input wire logic reg_set_out,
  input wire logic busy_out,
  input wire logic irq_ack_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  a_push_addr: assert property (irq_ack_out |-> mem_we_out && mem_addr_out == stack_pointer_register_out)
    else $error("push addr");
  a_push_status: assert property (irq_ack_out |-> mem_wdata_out == processor_status_word_out)
    else $error("push data");
  a_push_next: assert property (irq_ack_out ##1 mem_ack_in |=> mem_we_out && mem_addr_out == $past(mem_addr_out) - 16'h2)
    else $error("second push");
  a_mode_field: assert property (cur_mode_out == processor_status_word_out[IENT_MODE_HI:IENT_MODE_LO]
    && reg_set_out == processor_status_word_out[IENT_RSET_BIT]) else $error("mode field");
  a_hold_access: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("access dropped");
  a_no_take: assert property (!instr_boundary_in && !mem_req_out |=> !mem_req_out)
    else $error("taken off boundary");
  a_entry_span: assert property (irq_ack_out |-> mem_req_out [*4])
    else $error("entry broken");
  a_busy_req: assert property (busy_out == mem_req_out)
    else $error("busy");
endmodule : ient_chk
bind ient_seq ient_chk u_chk (.*);

// ---- tb/tb_top.sv ----
// Purpose: scenario bench for the sequencer
// Assumes: memory model acks after ack_delay_in cycles
// Notes: stack contents worked out by hand
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in, reset_in, irq_req_in, instr_boundary_in, return_from_interrupt_op_in, subroutine_call_op_in;
  logic subroutine_return_op_in, mem_req_out, mem_we_out, mem_ack_in, reg_set_out, busy_out, irq_ack_out;
  logic [8:0] irq_vector_in;
  logic [15:0] call_target_in, mem_addr_out, mem_wdata_out, mem_rdata_in, next_instruction_pointer_out;
  logic [15:0] processor_status_word_out, stack_pointer_register_out;
  logic [1:0] cur_mode_out;
  logic [3:0] ack_delay_in, ops;
  int fail_count = 0;
  int total_checks = 0;
  assign {irq_req_in, return_from_interrupt_op_in, subroutine_call_op_in, subroutine_return_op_in} = ops;
  wire [47:0] st = {next_instruction_pointer_out, processor_status_word_out, stack_pointer_register_out};
  ient_seq dut (.*);
  ient_mem_model mem (.*);
  initial begin
    clk_sys_in = 1'h0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // one request for one cycle, then a bounded wait for the end
  task automatic run(input logic [3:0] kind, input logic [3:0] dly);
    int n;
    ack_delay_in = dly;
    ops = kind;
    @(posedge clk_sys_in);
    #1 ops = 4'h0;
    for (n = 0; n < 60 && busy_out !== 1'h0; n++) @(posedge clk_sys_in) #1;
    if (n == 60) begin
      fail_count++;
      results();
    end
  endtask : run
  task automatic t_refuse();
    instr_boundary_in = 1'h0;
    ops = 4'h8;
    repeat (3) @(posedge clk_sys_in);
    #1 `CHK(busy_out, 1'h0)
    ops = 4'h0;
    instr_boundary_in = 1'h1;
  endtask : t_refuse
  task automatic t_entry();
    mem.m[16'h20] = 16'h1234;
    mem.m[16'h21] = 16'hc800;
    irq_vector_in = 9'h040;
    run(4'h8, 4'h0);
    `CHK(st, {16'h1234, 16'hc800, 16'hfffc})
    `CHK({cur_mode_out, reg_set_out}, 3'h7)
    `CHK({mem.m[16'h7fff], mem.m[16'h7ffe]}, 32'h0)
  endtask : t_entry
  task automatic t_nest();
    call_target_in = 16'h2000;
    run(4'h2, 4'h2);
    `CHK(mem.m[16'h7ffd], 16'h1234)
    mem.m[16'h28] = 16'h3000;
    mem.m[16'h29] = 16'h4000;
    irq_vector_in = 9'h050;
    run(4'h8, 4'h3);
    `CHK(st, {16'h3000, 16'h4000, 16'hfff6})
    `CHK({mem.m[16'h7ffc], mem.m[16'h7ffb]}, 32'hc8002000)
    `CHK({cur_mode_out, reg_set_out}, 3'h2)
  endtask : t_nest
  task automatic t_unwind();
    run(4'h4, 4'h1);
    `CHK(st, {16'h2000, 16'hc800, 16'hfffa})
    run(4'h1, 4'h1);
    `CHK(st, {16'h1234, 16'hc800, 16'hfffc})
    run(4'h4, 4'h0);
    `CHK(st, 48'h0)
  endtask : t_unwind
  initial begin
    reset_in = 1'h1;
    instr_boundary_in = 1'h1;
    ops = 4'h0;
    irq_vector_in = 9'h0;
    call_target_in = 16'h0;
    ack_delay_in = 4'h0;
    repeat (10) @(posedge clk_sys_in);
    #1 reset_in = 1'h0;
    t_refuse();
    t_entry();
    t_nest();
    t_unwind();
    results();
  end
endmodule : tb_top
